// ==== adc_result_trigger_regs.sv ====
// register side of a 10-bit converter: result bytes, trigger select, pin disables
// assumes a converter core that reports done with a 10-bit raw sample and a sign
`timescale 1ns/1ps
module adc_result_trigger_regs (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // converter core
    input wire logic conv_done,
    input wire logic [9:0] conv_raw,
    input wire logic conv_negative,
    output logic conv_start,
    output logic bipolar_select,
    output logic converter_enable,
    output logic comparator_mux_enable,
    // trigger flags from other peripherals, same clock
    input wire logic [7:0] trigger_flags,
    input wire logic vector_ack,
    // port pins
    input wire logic [7:0] pin_raw,
    output logic [7:0] pin_input,
    output logic [7:0] pin_input_disable,
    // interrupt
    output logic irq
);

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    logic [7:0] control_second;
    logic auto_trigger_enable;
    logic [7:0] status;
    logic [7:0] mask;
    logic locked;
    logic trig_prev;
    logic [7:0] pin_meta;
    logic [7:0] pin_sync;
    logic [9:0] next_value;
    logic trig_now;
    logic accept;
    logic wr_hit_status;
    logic wr_pin_disable;
    logic wr_control_first;
    logic wr_control_second;
    logic wr_irq_mask;
    logic rd_result_low;
    logic rd_result_high;
    logic dropped;
    result_if res ();

    result_store store (
        .clk(clk),
        .rstn(rstn),
        .res(res.store)
    );

    // decode a register hit
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // -----------------------------------------------------------------
    // register strobes
    // -----------------------------------------------------------------
    assign wr_pin_disable = wr && hit(addr, adc_regs_pkg::off_pin_disable);
    assign wr_control_first = wr && hit(addr, adc_regs_pkg::off_control_first);
    assign wr_control_second = wr && hit(addr, adc_regs_pkg::off_control_second);
    assign wr_irq_mask = wr && hit(addr, adc_regs_pkg::off_irq_mask);
    assign rd_result_low = rd && hit(addr, adc_regs_pkg::off_result_low);
    assign rd_result_high = rd && hit(addr, adc_regs_pkg::off_result_high);

    // -----------------------------------------------------------------
    // control registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            control_second <= adc_regs_pkg::reset_byte;
        end else if (wr_control_second) begin
            control_second <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            converter_enable <= 1'b0;
            auto_trigger_enable <= 1'b0;
        end else if (wr_control_first) begin
            converter_enable <= wdata[adc_regs_pkg::bit_enable];
            auto_trigger_enable <= wdata[adc_regs_pkg::bit_auto_trigger];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_input_disable <= adc_regs_pkg::reset_byte;
        end else if (wr_pin_disable) begin
            pin_input_disable <= wdata;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mask <= adc_regs_pkg::reset_byte;
        end else if (wr_irq_mask) begin
            mask <= wdata & adc_regs_pkg::irq_bits;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bipolar_select <= 1'b0;
            comparator_mux_enable <= 1'b0;
        end else begin
            bipolar_select <= control_second[adc_regs_pkg::bit_bipolar];
            comparator_mux_enable <= control_second[adc_regs_pkg::bit_comp_mux];
        end
    end

    // -----------------------------------------------------------------
    // result capture and read-order lock
    // -----------------------------------------------------------------
    // a completion in the cycle of a low-byte read is dropped as well: the
    // low byte just returned belongs to the held pair, which must stay whole
    assign accept = conv_done && !locked && !rd_result_low;
    assign dropped = conv_done && !accept;

    always_comb begin
        if (control_second[adc_regs_pkg::bit_bipolar]) begin
            // sign on top, nine magnitude bits two's complemented below
            next_value = conv_negative ? 10'((~{1'b0, conv_raw[8:0]}) + 10'h001) : {1'b0, conv_raw[8:0]};
        end else begin
            next_value = conv_negative ? 10'h3ff : conv_raw;
        end
    end

    assign res.load = accept;
    assign res.value = next_value;
    assign res.left_adjust = control_second[adc_regs_pkg::bit_left_adjust];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            locked <= 1'b0;
        end else if (rd_result_low) begin
            locked <= 1'b1;
        end else if (rd_result_high) begin
            locked <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // interrupt status
    // -----------------------------------------------------------------
    assign wr_hit_status = wr && hit(addr, adc_regs_pkg::off_irq_status);

    // a set in the same cycle as a clear wins, so no completion is lost
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status <= adc_regs_pkg::reset_byte;
        end else begin
            status[adc_regs_pkg::irq_done] <= accept
                || (status[adc_regs_pkg::irq_done]
                && !(wr_hit_status && wdata[adc_regs_pkg::irq_done]) && !vector_ack);
            status[adc_regs_pkg::irq_dropped] <= dropped
                || (status[adc_regs_pkg::irq_dropped]
                && !(wr_hit_status && wdata[adc_regs_pkg::irq_dropped]));
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    // -----------------------------------------------------------------
    // auto trigger
    // -----------------------------------------------------------------
    always_comb begin
        unique case (adc_regs_pkg::trigger_type'(control_second[2:0]))
            adc_regs_pkg::trig_free: trig_now = 1'b0;
            adc_regs_pkg::trig_comparator: trig_now = trigger_flags[1];
            adc_regs_pkg::trig_ext_int0: trig_now = trigger_flags[2];
            adc_regs_pkg::trig_t0_cmp_a: trig_now = trigger_flags[3];
            adc_regs_pkg::trig_t0_ovf: trig_now = trigger_flags[4];
            adc_regs_pkg::trig_t1_cmp_b: trig_now = trigger_flags[5];
            adc_regs_pkg::trig_t1_ovf: trig_now = trigger_flags[6];
            adc_regs_pkg::trig_t1_capture: trig_now = trigger_flags[7];
        endcase
    end

    // the previous level follows the selected mux output, so a reselect from a
    // clear source to a set one looks like a rising edge
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trig_prev <= 1'b0;
        end else begin
            trig_prev <= trig_now;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= converter_enable && auto_trigger_enable && trig_now && !trig_prev;
        end
    end

    // -----------------------------------------------------------------
    // pin inputs
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_meta <= adc_regs_pkg::reset_byte;
            pin_sync <= adc_regs_pkg::reset_byte;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_input <= adc_regs_pkg::reset_byte;
        end else begin
            pin_input <= pin_sync & ~pin_input_disable;
        end
    end

    // -----------------------------------------------------------------
    // read data
    // -----------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= adc_regs_pkg::reset_byte;
        end else if (rd) begin
            unique case (addr)
                adc_regs_pkg::off_pin_disable: rdata <= pin_input_disable;
                adc_regs_pkg::off_result_low: rdata <= res.low_byte;
                adc_regs_pkg::off_result_high: rdata <= res.high_byte;
                adc_regs_pkg::off_control_second: rdata <= control_second;
                adc_regs_pkg::off_control_first: rdata <= {converter_enable, 1'b0, auto_trigger_enable,
                    status[adc_regs_pkg::irq_done], 4'h0};
                adc_regs_pkg::off_irq_status: rdata <= status;
                adc_regs_pkg::off_irq_mask: rdata <= mask;
                default: rdata <= adc_regs_pkg::reset_byte;
            endcase
        end else begin
            rdata <= adc_regs_pkg::reset_byte;
        end
    end
endmodule

// ==== adc_regs_pkg.sv ====
// constants used by the converter register block, not by its result store
// assumes a byte-wide register port and a 10-bit converter core outside
package adc_regs_pkg;

    // -----------------------------------------------------------------
    // register offsets
    // -----------------------------------------------------------------
    localparam logic [7:0] off_pin_disable = 8'h01;
    localparam logic [7:0] off_result_low = 8'h04;
    localparam logic [7:0] off_result_high = 8'h05;
    localparam logic [7:0] off_control_second = 8'h06;
    localparam logic [7:0] off_control_first = 8'h07;
    localparam logic [7:0] off_irq_status = 8'h08;
    localparam logic [7:0] off_irq_mask = 8'h09;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int bit_bipolar = 7;
    localparam int bit_comp_mux = 6;
    localparam int bit_res_hi = 5;
    localparam int bit_left_adjust = 4;
    localparam int bit_res_lo = 3;
    localparam int bit_enable = 7;
    localparam int bit_auto_trigger = 5;
    localparam int irq_done = 0;
    localparam int irq_dropped = 1;

    localparam int result_width = 10;
    localparam int trig_sources = 8;

    // -----------------------------------------------------------------
    // reset values and masks
    // -----------------------------------------------------------------
    localparam logic [7:0] reset_byte = 8'h00;
    localparam logic [7:0] first_writable = 8'ha0;
    localparam logic [7:0] irq_bits = 8'h03;
    localparam logic [2:0] trig_free_running = 3'h0;

    typedef enum logic [2:0] {
        trig_free,
        trig_comparator,
        trig_ext_int0,
        trig_t0_cmp_a,
        trig_t0_ovf,
        trig_t1_cmp_b,
        trig_t1_ovf,
        trig_t1_capture
    } trigger_type;

endpackage

// ==== result_if.sv ====
// carries the captured conversion result between the control block and its store
// assumes one clock domain
`timescale 1ns/1ps
interface result_if;
    logic load;
    logic [9:0] value;
    logic left_adjust;
    logic [7:0] high_byte;
    logic [7:0] low_byte;

    modport ctrl (output load, output value, output left_adjust, input high_byte, input low_byte);
    modport store (input load, input value, input left_adjust, output high_byte, output low_byte);
endinterface

// ==== result_store.sv ====
// holds the last accepted conversion result and formats it into two bytes
// assumes load is only raised when the result pair is not locked
`timescale 1ns/1ps
module result_store (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // result path
    result_if.store res
);

    logic [9:0] held;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            held <= '0;
        end else if (res.load) begin
            held <= res.value;
        end
    end

    // formatting is combinational so a change of alignment shows at once
    always_comb begin
        if (res.left_adjust) begin
            res.high_byte = held[9:2];
            res.low_byte = {held[1:0], 6'h00};
        end else begin
            res.high_byte = {6'h00, held[9:8]};
            res.low_byte = held[7:0];
        end
    end
endmodule

// ==== adc_regs_asserts.sv ====
// port checker for the converter register block
// assumes a bind from the bench top
`timescale 1ns/1ps
module adc_regs_asserts (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // watched ports
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    input wire logic [7:0] trigger_flags,
    input wire logic conv_start,
    input wire logic converter_enable,
    input wire logic bipolar_select,
    input wire logic [7:0] pin_input,
    input wire logic [7:0] pin_input_disable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    a_start_one_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_start_from_flag: assert property (conv_start |-> $past(trigger_flags[7:1] != 7'h00))
        else $error("start without flag");
    a_start_needs_enable: assert property (conv_start |-> $past(converter_enable))
        else $error("start while disabled");
    a_read_data_quiet: assert property (rdata != 8'h00 |-> $past(rd))
        else $error("read data without read");
    a_disable_by_write: assert property (!$stable(pin_input_disable)
        |-> $past(wr && addr == 8'h01) && $past(wdata) == pin_input_disable)
        else $error("pin disable changed alone");
    a_bipolar_by_write: assert property (!$stable(bipolar_select)
        |-> $past(wr && addr == 8'h06, 2) && $past(wdata[7], 2) == bipolar_select)
        else $error("bipolar changed alone");
    a_enable_by_write: assert property (!$stable(converter_enable)
        |-> $past(wr && addr == 8'h07) && $past(wdata[7]) == converter_enable)
        else $error("enable changed alone");
    // mask latency is one cycle, so four stable samples more than settle the mask
    a_pin_forced_zero: assert property ($stable(pin_input_disable) [*4]
        |-> (pin_input & pin_input_disable) == 8'h00)
        else $error("disabled pin reads one");
    c_start: cover property (conv_start);
    c_read: cover property (rdata != 8'h00);
    c_masked: cover property (pin_input_disable != 8'h00);
endmodule

// ==== adc_result_trigger_regs_tb.sv ====
// self-checking bench for the converter register block
// assumes design files and checker compiled first
`timescale 1ns/1ps
module adc_result_trigger_regs_tb;
    // ------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic conv_done = 1'b0;
    logic [9:0] conv_raw = 10'h000;
    logic conv_negative = 1'b0;
    logic [7:0] trigger_flags = 8'h00;
    logic vector_ack = 1'b0;
    logic [7:0] pin_raw = 8'h00;
    logic [7:0] rdata;
    logic conv_start;
    logic bipolar_select;
    logic converter_enable;
    logic comparator_mux_enable;
    logic [7:0] pin_input;
    logic [7:0] pin_input_disable;
    logic irq;
    int fail_count = 0;
    int samples_checked = 0;
    int starts = 0;
    int cycles = 0;
    logic [15:0] v;
    logic [7:0] b;

    always #20 clk = ~clk;

    adc_result_trigger_regs dut (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata, .conv_done, .conv_raw,
        .conv_negative, .conv_start, .bipolar_select, .converter_enable, .comparator_mux_enable,
        .trigger_flags, .vector_ack, .pin_raw, .pin_input, .pin_input_disable, .irq);

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (conv_start === 1'b1)
            starts <= starts + 1;
        if (cycles == 5000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------
    // shared tasks
    // ------------------------------------------------
    task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // extra edge at the end keeps a strobe from being set twice in one step
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask

    task automatic read_pair(output logic [15:0] p);
        rd_reg(8'h04, p[7:0]);
        rd_reg(8'h05, p[15:8]);
    endtask

    task automatic convert(input logic [9:0] raw, input logic neg);
        conv_raw <= raw;
        conv_negative <= neg;
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        @(posedge clk);
    endtask

    // ------------------------------------------------
    // scenarios
    // ------------------------------------------------
    task automatic t_results;
        read_pair(v);
        check("reset pair", v, 16'h0000);
        rd_reg(8'h3f, b);
        check("unmapped", {8'h00, b}, 16'h0000);
        convert(10'h2a5, 1'b0);
        read_pair(v);
        check("right", v, 16'h02a5);
        wr_reg(8'h06, 8'h10);
        read_pair(v);
        check("left", v, 16'ha940);
        wr_reg(8'h06, 8'h00);
        rd_reg(8'h04, v[7:0]);
        check("realign", v, 16'ha9a5);
        rd_reg(8'h05, b);
    endtask

    task automatic t_irq;
        check("irq masked", {15'h0, irq}, 16'h0000);
        wr_reg(8'h09, 8'h01);
        idle(2);
        check("irq set", {15'h0, irq}, 16'h0001);
        wr_reg(8'h08, 8'h01);
        idle(2);
        check("irq clear", {15'h0, irq}, 16'h0000);
        convert(10'h001, 1'b0);
        vector_ack <= 1'b1;
        @(posedge clk);
        vector_ack <= 1'b0;
        check("irq done", {15'h0, irq}, 16'h0001);
        idle(2);
        check("ack clear", {15'h0, irq}, 16'h0000);
    endtask

    task automatic t_lock;
        convert(10'h155, 1'b0);
        rd_reg(8'h04, v[7:0]);
        convert(10'h2aa, 1'b0);
        rd_reg(8'h05, v[15:8]);
        check("locked", v, 16'h0155);
        read_pair(v);
        check("dropped", v, 16'h0155);
        rd_reg(8'h08, b);
        check("drop flag", {8'h00, b & 8'h02}, 16'h0002);
        addr <= 8'h04;
        rd <= 1'b1;
        conv_raw <= 10'h0aa;
        conv_done <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        conv_done <= 1'b0;
        @(negedge clk);
        v[7:0] = rdata;
        @(posedge clk);
        rd_reg(8'h05, v[15:8]);
        check("read race", v, 16'h0155);
    endtask

    task automatic t_format;
        wr_reg(8'h06, 8'hc0);
        idle(1);
        check("bipolar", {15'h0, bipolar_select}, 16'h0001);
        check("comp mux", {15'h0, comparator_mux_enable}, 16'h0001);
        convert(10'h005, 1'b1);
        read_pair(v);
        check("twos", v, 16'h03fb);
        wr_reg(8'h06, 8'h28);
        rd_reg(8'h06, b);
        check("reserved", {8'h00, b}, 16'h0028);
        convert(10'h005, 1'b1);
        read_pair(v);
        check("saturate", v, 16'h03ff);
    endtask

    task automatic t_trigger;
        int base;
        wr_reg(8'h07, 8'ha0);
        for (int c = 1; c < 8; c++) begin
            wr_reg(8'h06, 8'(c));
            base = starts;
            trigger_flags <= 8'hfe & ~(8'h01 << c);
            idle(3);
            trigger_flags <= 8'hfe;
            idle(3);
            check("code start", 16'(starts - base), 16'h0001);
            trigger_flags <= 8'h00;
            idle(2);
        end
        wr_reg(8'h06, 8'h02);
        trigger_flags <= 8'h08;
        idle(2);
        base = starts;
        wr_reg(8'h06, 8'h03);
        idle(2);
        check("reselect", 16'(starts - base), 16'h0001);
        base = starts;
        wr_reg(8'h06, 8'h00);
        idle(3);
        check("free quiet", 16'(starts - base), 16'h0000);
        wr_reg(8'h07, 8'h80);
        wr_reg(8'h06, 8'h02);
        trigger_flags <= 8'h04;
        idle(3);
        check("auto off", 16'(starts - base), 16'h0000);
        trigger_flags <= 8'h00;
    endtask

    task automatic t_pins;
        wr_reg(8'h01, 8'h0f);
        pin_raw <= 8'hff;
        idle(5);
        check("pin in", {8'h00, pin_input}, 16'h00f0);
        rd_reg(8'h01, b);
        check("disable", {b, pin_input_disable}, 16'h0f0f);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_results();
        t_irq();
        t_lock();
        t_format();
        t_trigger();
        t_pins();
        tally_and_finish();
    end
endmodule

bind adc_result_trigger_regs adc_regs_asserts chk (.clk, .rstn, .addr, .wdata, .wr, .rd, .rdata,
    .trigger_flags, .conv_start, .converter_enable, .bipolar_select, .pin_input, .pin_input_disable);
